// ---- hdl/mas_pkg.sv ----
package mas_pkg;

    // bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int CFG_W = 16;
    localparam int STEP_COUNT = 2;

    // register indices; the byte address is four times the index
    localparam logic [9:0] STEP4_CFG_IDX = 10'h0d4;
    localparam logic [9:0] STEP5_CFG_IDX = 10'h0d5;

    // values after reset
    localparam logic [15:0] STEP4_CFG_RESET = 16'h0004;
    localparam logic [15:0] STEP5_CFG_RESET = 16'h0005;

    // field positions
    localparam int ENABLE_BIT = 15;
    localparam int GAIN_HI = 14;
    localparam int GAIN_LO = 13;
    localparam int NEG_BIT = 4;
    localparam int POS_HI = 3;
    localparam int POS_EXT_FLAG = 3;

    // bits that store a value; bits 12..5 always read zero
    localparam logic [15:0] CFG_WRITABLE = 16'he01f;

    // gain codes and the gain factor they select
    localparam logic [1:0] GAIN_CODE_X1 = 2'h0;
    localparam logic [1:0] GAIN_CODE_X2 = 2'h1;
    localparam logic [2:0] GAIN_X1 = 3'h1;
    localparam logic [2:0] GAIN_X2 = 3'h2;
    localparam logic [2:0] GAIN_X4 = 3'h4;

    // internal sources, indexed by the low three bits of codes 8..15
    localparam logic [2:0] INT_TEMP_SENSOR = 3'h0;
    localparam logic [2:0] INT_SHORT_GROUND = 3'h1;
    localparam logic [2:0] INT_TEST_DAC = 3'h2;
    localparam logic [2:0] INT_ANALOG_SUPPLY_DIV4 = 3'h3;
    localparam logic [2:0] INT_IO_SUPPLY_DIV4 = 3'h4;
    localparam logic [2:0] INT_CORE_SUPPLY_DIV2 = 3'h5;
    localparam logic [2:0] INT_ANALOG_POWER_DIV103 = 3'h6;
    localparam logic [2:0] INT_DIGITAL_POWER_DIV103 = 3'h7;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // negative input routing
    typedef enum logic [1:0] {
        NEG_GROUND = 2'h0,
        NEG_EXT_SEVEN = 2'h1,
        NEG_AUTO = 2'h3
    } mas_neg_e;

endpackage : mas_pkg

// ---- hdl/mas_step_decode.sv ----
`timescale 1ns/1ps
module mas_step_decode #(
    parameter logic [15:0] RESET_CFG = 16'h0000
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] cfg,
    output logic step_enable,
    output logic [2:0] gain_factor,
    output logic pos_is_external,
    output logic [2:0] pos_channel,
    output logic [2:0] pos_internal,
    output mas_pkg::mas_neg_e neg_select
);

    ////////////////////////////////////////////////////////////////////////
    // field decode, shared by the reset image and the live value
    function automatic logic [10:0] decode(input logic [15:0] c);
        logic [2:0] gain;
        logic [1:0] neg;
        logic ext;
        gain = mas_pkg::GAIN_X4; // codes 2 and 3 both mean four
        if (c[mas_pkg::GAIN_HI:mas_pkg::GAIN_LO] == mas_pkg::GAIN_CODE_X1)
            gain = mas_pkg::GAIN_X1;
        else if (c[mas_pkg::GAIN_HI:mas_pkg::GAIN_LO] == mas_pkg::GAIN_CODE_X2)
            gain = mas_pkg::GAIN_X2;
        ext = !c[mas_pkg::POS_EXT_FLAG];
        // internal sources pick their own negative side, bit 4 unused
        if (!ext)
            neg = mas_pkg::NEG_AUTO;
        else if (c[mas_pkg::NEG_BIT])
            neg = mas_pkg::NEG_EXT_SEVEN;
        else
            neg = mas_pkg::NEG_GROUND;
        // bit 2 of the image is a spare so the fields keep their slots
        decode = {c[mas_pkg::ENABLE_BIT], gain, ext, c[2:0], 1'b0,
                  neg};
    endfunction : decode

    localparam logic [10:0] RESET_IMAGE = decode(RESET_CFG);

    logic [10:0] image_reg;
    logic [10:0] image_next;

    assign image_next = decode(cfg);

    ////////////////////////////////////////////////////////////////////////
    // registered so the analog switches see a clean, glitch-free control
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            image_reg <= RESET_IMAGE;
        end else begin
            image_reg <= image_next;
        end
    end

    // external codes 0..7 route inputs zero..seven; 8..15 internal
    assign step_enable = image_reg[10];
    assign gain_factor = image_reg[9:7];
    assign pos_is_external = image_reg[6];
    assign pos_channel = image_reg[6] ? image_reg[5:3] : 3'h0;
    assign pos_internal = image_reg[6] ? 3'h0 : image_reg[5:3];
    assign neg_select = mas_pkg::mas_neg_e'(image_reg[1:0]);

endmodule : mas_step_decode

// ---- hdl/mas_seq_step_cfg.sv ----
// Operation
// - step runs only while its enable bit is set
// - gain codes 0,1,2,3 give one, two, four, four
// - bit 4 picks ground or external input seven
// - positive codes 0..7 pick external inputs 0..7
// - codes 8 and up choose negative input automatically
// - codes 8..15 select internal sources and supply monitors
// - step 4 register at D4, resets to 0004
// - step 5 register at D5, resets to 0005
`timescale 1ns/1ps
module mas_seq_step_cfg (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [1:0] step_enable,
    output logic [1:0][2:0] step_gain_factor,
    output logic [1:0] step_pos_is_external,
    output logic [1:0][2:0] step_pos_channel,
    output logic [1:0][2:0] step_pos_internal,
    output logic [1:0][1:0] step_neg_input_select
);

    ////////////////////////////////////////////////////////////////////////
    // address decode: one-hot per step, index 0 is step 4
    function automatic logic [1:0] reg_sel(input logic [11:0] addr);
        reg_sel[0] = (addr[11:2] == mas_pkg::STEP4_CFG_IDX);
        reg_sel[1] = (addr[11:2] == mas_pkg::STEP5_CFG_IDX);
    endfunction : reg_sel

    logic aw_held_reg;
    logic [11:0] aw_addr_reg;
    logic w_held_reg;
    logic [15:0] w_data_reg;
    logic [1:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [15:0] cfg_reg [2];
    logic [15:0] cfg_next [2];

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    wire [1:0] wr_sel = reg_sel(aw_addr_reg);
    wire [1:0] rd_sel = reg_sel(s_axi_araddr);
    wire [15:0] byte_mask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    wire [15:0] rd_word = rd_sel[0] ? cfg_reg[0] :
                          rd_sel[1] ? cfg_reg[1] : 16'h0000;

    // address and data are taken in any order; nothing new while answering
    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    ////////////////////////////////////////////////////////////////////////
    // write channel capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
        end else if (aw_take) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    // only the low half of the word is kept; the upper lanes hold nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 16'h0000;
            w_strb_reg <= 2'h0;
        end else if (w_take) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata[15:0];
            w_strb_reg <= s_axi_wstrb[1:0];
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    // write response; an unmapped address answers with a slave error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= mas_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (|wr_sel) ? mas_pkg::RESP_OKAY : mas_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel; data is registered at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= mas_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= {16'h0000, rd_word};
            rresp_reg <= (|rd_sel) ? mas_pkg::RESP_OKAY : mas_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // step configuration words and their decoders
    localparam logic [15:0] STEP_RESET [2] = '{mas_pkg::STEP4_CFG_RESET,
                                               mas_pkg::STEP5_CFG_RESET};

    generate
        for (genvar i = 0; i < mas_pkg::STEP_COUNT; i++) begin : g_step
            // byte lanes merged, reserved bits forced to zero
            assign cfg_next[i] = ((cfg_reg[i] & ~byte_mask) |
                                  (w_data_reg & byte_mask)) &
                                 mas_pkg::CFG_WRITABLE;

            // reset image per step
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    cfg_reg[i] <= STEP_RESET[i];
                end else if (wr_fire && wr_sel[i]) begin
                    cfg_reg[i] <= cfg_next[i];
                end
            end

            mas_step_decode #(
                .RESET_CFG(STEP_RESET[i])
            ) u_decode (
                .aclk(aclk),
                .aresetn(aresetn),
                .cfg(cfg_reg[i]),
                .step_enable(step_enable[i]),
                .gain_factor(step_gain_factor[i]),
                .pos_is_external(step_pos_is_external[i]),
                .pos_channel(step_pos_channel[i]),
                .pos_internal(step_pos_internal[i]),
                .neg_select(step_neg_input_select[i])
            );
        end
    endgenerate

endmodule : mas_seq_step_cfg

// ---- tb/mas_seq_step_cfg_sva.sv ----
`timescale 1ns/1ps
module mas_seq_step_cfg_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] step_enable,
    input wire logic [1:0][2:0] step_gain_factor,
    input wire logic [1:0] step_pos_is_external,
    input wire logic [1:0][2:0] step_pos_channel,
    input wire logic [1:0][2:0] step_pos_internal,
    input wire logic [1:0][1:0] step_neg_input_select
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////
    // decoded step fields must stay consistent with each other
    chk_auto_neg: assert property (
        !step_pos_is_external[0] |-> step_neg_input_select[0] == 2'h3)
        else $error("negative input not automatic");
    chk_ext_route: assert property (
        step_pos_is_external[1] |->
        step_pos_internal[1] == 3'h0 && !step_neg_input_select[1][1])
        else $error("external route shows internal fields");
    chk_int_route: assert property (
        !step_pos_is_external[1] |-> step_pos_channel[1] == 3'h0)
        else $error("internal route shows a channel");
    chk_gain_code: assert property (
        step_gain_factor[0] inside {3'h1, 3'h2, 3'h4} &&
        step_gain_factor[1] inside {3'h1, 3'h2, 3'h4})
        else $error("illegal gain factor");
    ////////////////////////////////////////////////////////////////////////
    // bus answers; a lost hold would drop data under a slow master
    chk_rsvd_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0 &&
        s_axi_rdata[12:5] == 8'h0) else $error("reserved bits set");
    chk_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    chk_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    // enable only moves one cycle after a write response
    chk_enable_src: assert property (
        $changed(step_enable) |-> $past(s_axi_bvalid))
        else $error("enable changed without a write");
endmodule : mas_seq_step_cfg_sva

// ---- tb/mas_seq_step_cfg_tb.sv ----
`timescale 1ns/1ps
module mas_seq_step_cfg_tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs, step_enable, step_pos_is_external;
    logic [1:0][2:0] step_gain_factor, step_pos_channel, step_pos_internal;
    logic [1:0][1:0] step_neg_input_select;
    logic [15:0] mdl [2];
    int err_count, checks, seed;
    mas_seq_step_cfg i_dut (.*);
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    task automatic chk(input string n, input logic [31:0] e, s);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // byte address is four times the register index
    function automatic logic [11:0] addr(input int k);
        return 12'h350 + 12'(4 * k);
    endfunction : addr
    // ready is sampled at negedge, so the handshake edge is never raced
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] st);
        logic aw, w, b;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(negedge aclk);
            aw = s_axi_awready;
            w = s_axi_wready;
            b = s_axi_bvalid;
            rs = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) break;
        end
        s_axi_bready <= 1'b0;
        if (!b) begin
            err_count++;
            results();
        end
    endtask : wr
    task automatic rd_reg(input logic [11:0] a);
        logic ar, r;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(negedge aclk);
            ar = s_axi_arready;
            r = s_axi_rvalid;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (r) break;
        end
        s_axi_rready <= 1'b0;
        if (!r) begin
            err_count++;
            results();
        end
    endtask : rd_reg
    // reference decode of one step from the model word
    task automatic chk_step(input int k);
        logic [15:0] r;
        logic x;
        r = mdl[k];
        x = !r[3];
        chk("enable", 32'(r[15]), 32'(step_enable[k]));
        chk("gain", r[14] ? 4 : (r[13] ? 2 : 1),
            32'(step_gain_factor[k]));
        chk("pos", {x, x ? r[2:0] : 3'h0},
            {step_pos_is_external[k], step_pos_channel[k]});
        chk("internal", x ? 3'h0 : r[2:0],
            32'(step_pos_internal[k]));
        chk("neg", x ? {1'b0, r[4]} : 2'h3,
            32'(step_neg_input_select[k]));
    endtask : chk_step
    task automatic post_reset;
        mdl[0] = 16'h0004;
        mdl[1] = 16'h0005;
        for (int k = 0; k < 2; k++) begin
            rd_reg(addr(k));
            chk("reset value", 32'(mdl[k]), rd);
            chk_step(k);
        end
        $display("test reset values done");
    endtask : post_reset
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int k;
        logic [31:0] d;
        logic [3:0] st;
        logic [15:0] bm;
        seed = 37;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_wstrb} = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        post_reset();
        // random words, every positive code, random partial strobes
        for (int i = 0; i < 48; i++) begin
            k = i % 2;
            d = $random(seed);
            st = i < 16 ? 4'hf : 4'($random(seed));
            if (i < 16) d[3:0] = i[3:0];
            wr(addr(k), d, st);
            chk("bresp", 2'h0, rs);
            bm = {{8{st[1]}}, {8{st[0]}}};
            mdl[k] = (mdl[k] & ~bm | d[15:0] & bm) & 16'he01f;
            rd_reg(addr(k));
            chk("readback", 32'(mdl[k]), rd);
            chk_step(k);
        end
        $display("test random writes done");
        // unmapped neighbour: refused and no register disturbed
        wr(12'h358, 32'hffff, 4'hf);
        chk("bresp unmapped", 2'h2, rs);
        rd_reg(12'h358);
        chk("rresp unmapped", 32'h2, 32'(rs));
        chk("rdata unmapped", 32'h0, rd);
        for (k = 0; k < 2; k++) begin
            rd_reg(addr(k));
            chk("kept", 32'(mdl[k]), rd);
        end
        $display("test unmapped done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        post_reset();
        results();
    end
endmodule : mas_seq_step_cfg_tb
bind mas_seq_step_cfg mas_seq_step_cfg_sva i_sva (.*);
